// *** bmx_consts.svh ***
// Constants for the branch and block move execution unit
// Assumes a single 20 MHz clock and synchronous active-low reset
`ifndef BMX_CONSTS_SVH
`define BMX_CONSTS_SVH
`define BMX_OP_BRANCH 8'hf2
`define BMX_OP_BLKDATA 8'hfd
`define BMX_OP_BLKPROG 8'hfc
`define BMX_IND_BIT 7
`define BMX_ROM_LIMIT 16'h1000
`define BMX_PC_STEP 16'h0002
`define BMX_ONE 16'h0001
`endif

// *** bmx_pkg.sv ***
// Types for the branch and block move execution unit
// Assumes the constants header is included alongside
package bmx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH2 = 3'b001,
    ST_READ = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } bmx_state_t;
endpackage : bmx_pkg

// *** bmx_buf_if.sv ***
// Word stream between the move engine and its buffer
// Assumes both ends share clock_i
`timescale 1ns/1ps
interface bmx_buf_if;
  logic valid;
  logic ready;
  logic [15:0] data;
  logic [15:0] addr;
  modport src (output valid, output data, output addr, input ready);
  modport dst (input valid, input data, input addr, output ready);
endinterface : bmx_buf_if

// *** bmx_buf.sv ***
// Two-entry skid buffer for move words
// Assumes one clock; drain side may stall
`timescale 1ns/1ps
module bmx_buf (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Fill side
  bmx_buf_if.dst in_if,
  // Drain side
  output logic out_valid_o,
  output logic [15:0] out_data_o,
  output logic [15:0] out_addr_o,
  input wire logic out_ready_i
);
  logic [31:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;
  assign in_if.ready = (cnt_q != 2'h2);
  assign push = in_if.valid && in_if.ready;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rp_q][15:0];
  assign out_addr_o = mem_q[rp_q][31:16];
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wp_q] <= {in_if.addr, in_if.data};
    end
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : bmx_buf

// *** bmx_exec.sv ***
// Execution unit for branch-if-nonpositive and the two block moves
// Assumes memory answers reads with a one-cycle ack pulse
`timescale 1ns/1ps
`include "bmx_consts.svh"
module bmx_exec
  import bmx_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Instruction issue
  input wire logic start_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] word2_i,
  input wire logic word2_valid_i,
  input wire logic [15:0] pc_i,
  input wire logic [31:0] sum_register_i,
  input wire logic repeat_prefix_i,
  input wire logic [15:0] repeat_count_reg_i,
  input wire logic [15:0] prefetch_counter_i,
  input wire logic [15:0] current_aux_register_i,
  input wire logic [2:0] aux_pointer_field_i,
  input wire logic micro_mode_select_i,
  // Indirect field results
  input wire logic ind_modify_i,
  input wire logic [15:0] ind_aux_next_i,
  input wire logic ind_arp_load_i,
  input wire logic [2:0] ind_arp_next_i,
  // Source read port
  output logic rd_req_o,
  output logic [15:0] rd_addr_o,
  output logic rd_prog_o,
  output logic rd_rom_o,
  input wire logic rd_ack_i,
  input wire logic [15:0] rd_data_i,
  // Destination write port
  output logic wr_valid_o,
  output logic [15:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  input wire logic wr_ready_i,
  // Core state results
  output logic [15:0] pc_o,
  output logic [15:0] prefetch_counter_o,
  output logic [15:0] microcall_stack_o,
  output logic [15:0] repeat_count_reg_o,
  output logic [15:0] current_aux_register_o,
  output logic [2:0] aux_pointer_field_o,
  output logic int_hold_o,
  output logic busy_o,
  output logic done_o
);
  ////////////////////////////////////////////////////////////////
  bmx_state_t state_q;
  logic is_br;
  logic is_bd;
  logic is_bp;
  logic ind_q;
  logic prog_q;
  logic [15:0] word_q;
  logic last;
  logic [15:0] dst_addr;
  logic bvalid_q;
  logic [15:0] bdata_q;
  logic [15:0] baddr_q;
  logic wvalid;
  logic [15:0] wdata;
  logic [15:0] waddr;
  logic rd_wait_q;
  logic mm_s1_q;
  logic mm_s2_q;
  logic mm_s3_q;
  logic mm_q;
  bmx_buf_if bif ();
  assign is_br = (opcode_i[15:8] == `BMX_OP_BRANCH) && opcode_i[`BMX_IND_BIT];
  assign is_bd = (opcode_i[15:8] == `BMX_OP_BLKDATA);
  assign is_bp = (opcode_i[15:8] == `BMX_OP_BLKPROG);
  assign last = (repeat_count_reg_o == 16'h0000);
  assign dst_addr = ind_q ? current_aux_register_o : {9'h000, word_q[6:0]};
  assign bif.valid = bvalid_q;
  assign bif.data = bdata_q;
  assign bif.addr = baddr_q;

  ////////////////////////////////////////////////////////////////
  // Mode pin filter
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mm_s1_q <= 1'b0;
      mm_s2_q <= 1'b0;
      mm_s3_q <= 1'b0;
      mm_q <= 1'b0;
    end else begin
      mm_s1_q <= micro_mode_select_i;
      mm_s2_q <= mm_s1_q;
      mm_s3_q <= mm_s2_q;
      if (mm_s2_q == mm_s3_q) mm_q <= mm_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      ind_q <= 1'b0;
      prog_q <= 1'b0;
      word_q <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_i && (is_br || is_bd || is_bp)) begin
            ind_q <= opcode_i[`BMX_IND_BIT];
            prog_q <= is_bp;
            word_q <= opcode_i;
            state_q <= is_br ? ST_DONE : ST_FETCH2;
          end
        end
        ST_FETCH2: if (word2_valid_i) state_q <= ST_READ;
        ST_READ: if (rd_ack_i) state_q <= ST_WAIT;
        ST_WAIT: begin
          if (bif.ready) begin
            state_q <= last ? ST_DONE : ST_READ;
          end
        end
        ST_DONE: begin
          done_o <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Program counter and branch
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pc_o <= 16'h0000;
    end else if (state_q == ST_IDLE && start_i && is_br) begin
      if ($signed(sum_register_i) <= 0) pc_o <= word2_i;
      else pc_o <= pc_i + `BMX_PC_STEP;
    end else if (state_q == ST_IDLE && start_i && (is_bd || is_bp)) begin
      pc_o <= pc_i + `BMX_PC_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Aux register and pointer
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      current_aux_register_o <= 16'h0000;
      aux_pointer_field_o <= 3'h0;
    end else if (state_q == ST_IDLE && start_i) begin
      current_aux_register_o <= current_aux_register_i;
      aux_pointer_field_o <= aux_pointer_field_i;
      if (is_br && ind_modify_i) current_aux_register_o <= ind_aux_next_i;
      if (is_br && ind_arp_load_i) aux_pointer_field_o <= ind_arp_next_i;
    end else if (state_q == ST_WAIT && bif.ready && ind_q) begin
      current_aux_register_o <= current_aux_register_o + `BMX_ONE;
      if (last && ind_arp_load_i) aux_pointer_field_o <= ind_arp_next_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Prefetch counter, stack and repeat count
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      prefetch_counter_o <= 16'h0000;
      microcall_stack_o <= 16'h0000;
      repeat_count_reg_o <= 16'h0000;
    end else if (state_q == ST_IDLE && start_i && (is_bd || is_bp)) begin
      microcall_stack_o <= prefetch_counter_i;
      repeat_count_reg_o <= repeat_count_reg_i;
    end else if (state_q == ST_FETCH2 && word2_valid_i) begin
      prefetch_counter_o <= word2_i;
    end else if (state_q == ST_WAIT && bif.ready) begin
      if (last) begin
        prefetch_counter_o <= microcall_stack_o;
      end else begin
        prefetch_counter_o <= prefetch_counter_o + `BMX_ONE;
        repeat_count_reg_o <= repeat_count_reg_o - `BMX_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Source read request
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= 16'h0000;
      rd_prog_o <= 1'b0;
      rd_rom_o <= 1'b0;
    end else begin
      rd_req_o <= (state_q == ST_READ) && !rd_ack_i && !rd_req_o && !rd_wait_q;
      rd_addr_o <= prefetch_counter_o;
      rd_prog_o <= prog_q;
      rd_rom_o <= prog_q && !mm_q && (prefetch_counter_o < `BMX_ROM_LIMIT);
    end
  end

  // Outstanding read, one request per word
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_wait_q <= 1'b0;
    end else if (rd_req_o) begin
      rd_wait_q <= 1'b1;
    end else if (rd_ack_i) begin
      rd_wait_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Word into the buffer
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      bvalid_q <= 1'b0;
      bdata_q <= 16'h0000;
      baddr_q <= 16'h0000;
    end else if (state_q == ST_READ && rd_ack_i) begin
      bvalid_q <= 1'b1;
      bdata_q <= rd_data_i;
      baddr_q <= dst_addr;
    end else if (bif.ready) begin
      bvalid_q <= 1'b0;
    end
  end

  bmx_buf u_buf (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .in_if(bif),
    .out_valid_o(wvalid),
    .out_data_o(wdata),
    .out_addr_o(waddr),
    .out_ready_i(wr_ready_i || !wr_valid_o)
  );

  ////////////////////////////////////////////////////////////////
  // Destination write and status
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_valid_o <= 1'b0;
      wr_addr_o <= 16'h0000;
      wr_data_o <= 16'h0000;
    end else if (wr_ready_i || !wr_valid_o) begin
      wr_valid_o <= wvalid;
      wr_addr_o <= waddr;
      wr_data_o <= wdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      int_hold_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      if (state_q == ST_IDLE) busy_o <= start_i && (is_br || is_bd || is_bp);
      else busy_o <= (state_q != ST_DONE);
      if (state_q == ST_IDLE && start_i && is_bp) int_hold_o <= 1'b1;
      else if (state_q == ST_IDLE && start_i && is_bd) int_hold_o <= repeat_prefix_i;
      else if (state_q == ST_DONE) int_hold_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_branch_taken;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == ST_IDLE && start_i && is_br && $signed(sum_register_i) <= 0)
      |=> pc_o == $past(word2_i);
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("branch target not loaded");
  property p_branch_skip;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == ST_IDLE && start_i && is_br && $signed(sum_register_i) > 0)
      |=> pc_o == $past(pc_i) + 16'h0002;
  endproperty
  a_branch_skip: assert property (p_branch_skip) else $error("pc not stepped by two");
  property p_count_zero;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == ST_DONE) |-> repeat_count_reg_o == 16'h0000;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("repeat count not zero at end");
  property p_hold_prog;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q != ST_IDLE && prog_q) |-> int_hold_o;
  endproperty
  a_hold_prog: assert property (p_hold_prog) else $error("interrupts not held");
  property p_rom_sel;
    @(posedge clock_i) disable iff (!resetn_i)
      rd_req_o && rd_prog_o && !$past(mm_q) && rd_addr_o < 16'h1000 |-> rd_rom_o;
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom not selected");
  property p_src_step;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == ST_WAIT && bif.ready && !last) |=> prefetch_counter_o == $past(prefetch_counter_o) + 16'h0001;
  endproperty
  a_src_step: assert property (p_src_step) else $error("source not advanced");
  property p_dst_fixed;
    @(posedge clock_i) disable iff (!resetn_i)
      (bvalid_q && !ind_q) |-> baddr_q == {9'h000, word_q[6:0]};
  endproperty
  a_dst_fixed: assert property (p_dst_fixed) else $error("direct destination moved");
  property p_save_pfc;
    @(posedge clock_i) disable iff (!resetn_i)
      (state_q == ST_IDLE && start_i && (is_bd || is_bp)) |=> microcall_stack_o == $past(prefetch_counter_i);
  endproperty
  a_save_pfc: assert property (p_save_pfc) else $error("prefetch not saved");
endmodule : bmx_exec

// *** bmx_mem.sv ***
// Memory model on the far side of the move engine
// Assumes reads are single pulses; writes use valid and ready
`timescale 1ns/1ps
module bmx_mem (
  // Clock
  input wire logic clock_i,
  // Read side
  input wire logic rd_req_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic rd_prog_i,
  output logic rd_ack_o,
  output logic [15:0] rd_data_o,
  // Write side
  output logic wr_ready_o
);
  logic [2:0] cyc_q = 3'h0;
  logic pend_q = 1'b0;
  logic slow_q = 1'b0;
  logic [15:0] word_q = 16'h0;
  initial begin
    rd_ack_o = 1'b0;
    rd_data_o = 16'h0;
    wr_ready_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // Answers in one or two cycles, stalls writes one cycle in eight
  always @(posedge clock_i) begin
    cyc_q <= cyc_q + 3'h1;
    wr_ready_o <= (cyc_q != 3'h5);
    rd_ack_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (rd_req_i) begin
      word_q <= rd_addr_i ^ (rd_prog_i ? 16'hc3c3 : 16'h3c3c);
      pend_q <= 1'b1;
      slow_q <= cyc_q[0];
    end else if (pend_q && slow_q) begin
      slow_q <= 1'b0;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      rd_ack_o <= 1'b1;
      rd_data_o <= word_q;
    end
  end
endmodule : bmx_mem

// *** branch_le_and_block_move_exec_bench.sv ***
// Bench for the branch and block move execution unit
// Assumes bmx_mem answers reads and stalls writes
`timescale 1ns/1ps
module branch_le_and_block_move_exec_bench;
  logic clock_i, resetn_i, start_i, word2_valid_i, repeat_prefix_i;
  logic micro_mode_select_i, ind_modify_i, ind_arp_load_i;
  logic [15:0] opcode_i, word2_i, pc_i, repeat_count_reg_i, prefetch_counter_i;
  logic [15:0] current_aux_register_i, ind_aux_next_i;
  logic [31:0] sum_register_i;
  logic [2:0] aux_pointer_field_i, ind_arp_next_i, aux_pointer_field_o;
  logic rd_req_o, rd_prog_o, rd_rom_o, rd_ack_i, wr_valid_o, wr_ready_i;
  logic int_hold_o, busy_o, done_o;
  logic [15:0] rd_addr_o, rd_data_i, wr_addr_o, wr_data_o, pc_o;
  logic [15:0] prefetch_counter_o, microcall_stack_o, repeat_count_reg_o;
  logic [15:0] current_aux_register_o;
  int bad_count, checks, nw, nr, cyc;
  logic [15:0] wa[16], wd[16], ra[16];
  logic rr[16], rp[16], hold_seen;

  bmx_exec u_bmx_exec (.clock_i(clock_i), .resetn_i(resetn_i), .start_i(start_i),
    .opcode_i(opcode_i), .word2_i(word2_i), .word2_valid_i(word2_valid_i), .pc_i(pc_i),
    .sum_register_i(sum_register_i), .repeat_prefix_i(repeat_prefix_i),
    .repeat_count_reg_i(repeat_count_reg_i), .prefetch_counter_i(prefetch_counter_i),
    .current_aux_register_i(current_aux_register_i),
    .aux_pointer_field_i(aux_pointer_field_i), .micro_mode_select_i(micro_mode_select_i),
    .ind_modify_i(ind_modify_i), .ind_aux_next_i(ind_aux_next_i),
    .ind_arp_load_i(ind_arp_load_i), .ind_arp_next_i(ind_arp_next_i),
    .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_prog_o(rd_prog_o), .rd_rom_o(rd_rom_o),
    .rd_ack_i(rd_ack_i), .rd_data_i(rd_data_i), .wr_valid_o(wr_valid_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .pc_o(pc_o),
    .prefetch_counter_o(prefetch_counter_o), .microcall_stack_o(microcall_stack_o),
    .repeat_count_reg_o(repeat_count_reg_o),
    .current_aux_register_o(current_aux_register_o),
    .aux_pointer_field_o(aux_pointer_field_o), .int_hold_o(int_hold_o), .busy_o(busy_o),
    .done_o(done_o));
  bmx_mem u_bmx_mem (.clock_i(clock_i), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .rd_prog_i(rd_prog_o), .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i),
    .wr_ready_o(wr_ready_i));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  // Transfer log and watchdog
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
    if (wr_valid_o && wr_ready_i) begin
      wa[nw % 16] = wr_addr_o;
      wd[nw % 16] = wr_data_o;
      nw++;
    end
    if (rd_req_o) begin
      ra[nr % 16] = rd_addr_o;
      rr[nr % 16] = rd_rom_o;
      rp[nr % 16] = rd_prog_o;
      nr++;
    end
    if (int_hold_o === 1'b1) hold_seen = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task tick();
    @(posedge clock_i);
    #5;
  endtask : tick

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task go(input logic [15:0] op, w2, input logic [31:0] s, input logic [15:0] repeat_next_instr,
          input logic pfx, mm);
    opcode_i = op;
    word2_i = w2;
    sum_register_i = s;
    repeat_count_reg_i = repeat_next_instr;
    repeat_prefix_i = pfx;
    micro_mode_select_i = mm;
    nw = 0;
    nr = 0;
    hold_seen = 1'b0;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    word2_valid_i = 1'b1;
    tick();
    word2_valid_i = 1'b0;
    for (int i = 0; i < 300 && done_o !== 1'b1; i++) tick();
    chk("done", 1, done_o);
    repeat (4) tick();
  endtask : go

  task br(input logic [31:0] s, input logic m, input logic [15:0] epc);
    ind_modify_i = m;
    ind_arp_load_i = m;
    go(16'hf2a1, 16'h3c00, s, 16'h0, 1'b0, 1'b0);
    chk("pc", epc, pc_o);
    chk("aux", m ? 16'h1234 : 16'h0406, current_aux_register_o);
    chk("arp", m ? 3'h7 : 3'h2, aux_pointer_field_o);
    ind_modify_i = 1'b0;
    ind_arp_load_i = 1'b0;
    $display("branch test done");
  endtask : br

  task mv(input logic [15:0] op, src, repeat_next_instr, input logic pfx, mm);
    logic p;
    logic [15:0] a;
    p = (op[15:8] == 8'hfc);
    micro_mode_select_i = mm;
    repeat (4) tick();
    go(op, src, 32'h0, repeat_next_instr, pfx, mm);
    chk("words", repeat_next_instr + 1, nw);
    for (int k = 0; k <= repeat_next_instr; k++) begin
      a = src + k[15:0];
      chk("raddr", a, ra[k]);
      chk("prog", p, rp[k]);
      chk("rom", p && !mm && a < 16'h1000, rr[k]);
      chk("waddr", op[7] ? 16'h0406 + k[15:0] : {9'h0, op[6:0]}, wa[k]);
      chk("wdata", a ^ (p ? 16'hc3c3 : 16'h3c3c), wd[k]);
    end
    chk("count", 0, repeat_count_reg_o);
    chk("pc", 16'h0102, pc_o);
    chk("stack", 16'h0200, microcall_stack_o);
    chk("pfc", 16'h0200, prefetch_counter_o);
    chk("aux", op[7] ? 16'h0407 + repeat_next_instr : 16'h0406, current_aux_register_o);
    chk("hold", p | pfx, hold_seen);
    $display("move test done");
  endtask : mv

  task final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, start_i, word2_valid_i, repeat_prefix_i, micro_mode_select_i} = 5'h0;
    {ind_modify_i, ind_arp_load_i} = 2'h0;
    {opcode_i, word2_i, repeat_count_reg_i, sum_register_i} = 64'h0;
    pc_i = 16'h0100;
    prefetch_counter_i = 16'h0200;
    current_aux_register_i = 16'h0406;
    aux_pointer_field_i = 3'h2;
    ind_aux_next_i = 16'h1234;
    ind_arp_next_i = 3'h7;
    repeat (8) tick();
    resetn_i = 1'b1;
    br(32'h0, 1'b1, 16'h3c00);
    br(32'hfffffffb, 1'b0, 16'h3c00);
    br(32'h1, 1'b1, 16'h0102);
    opcode_i = 16'hf221;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    chk("busy", 0, busy_o);
    tick();
    chk("done", 0, done_o);
    chk("pc", 16'h0102, pc_o);
    mv(16'hfda0, 16'hf400, 16'h2, 1'b1, 1'b0);
    mv(16'hfd25, 16'h0300, 16'h3, 1'b1, 1'b0);
    mv(16'hfd88, 16'h0310, 16'h0, 1'b0, 1'b0);
    mv(16'hfca8, 16'h0ffe, 16'h2, 1'b1, 1'b0);
    mv(16'hfc31, 16'h0020, 16'h1, 1'b1, 1'b1);
    final_report();
  end
endmodule : branch_le_and_block_move_exec_bench
